/* hdl/dram_phy_cfg_defs.svh */
// Offsets, field positions, reset values and timing counts for the DRAM interface config block.
`ifndef DRAM_PHY_CFG_DEFS_SVH
`define DRAM_PHY_CFG_DEFS_SVH

// Register offsets on the configuration port.
`define OFS_INDIRECT_INDEX      8'h98
`define OFS_INDIRECT_DATA_PORT  8'h9C
`define OFS_CLOCK_RATE          8'h94

// Indirect array extent and the one register held here.
`define IDX_LAST                30'h0000001B
`define IDX_OUTPUT_DRIVER       30'h00000000

// Index register layout and reset.
`define INDEX_COMPLETE_BIT      31
`define INDEX_WRITE_BIT         30
`define INDEX_RESET             32'h80000000
`define INDEX_RW_MASK           32'h7FFFFFFF

// Output driver register reset and writable-bit mask.
`define DRV_RESET               32'h00111222
`define DRV_RW_MASK             32'h30333333
`define DRV_ODT_LSB             28
`define DRV_STROBE_LSB          20
`define DRV_DATA_LSB            16
`define DRV_MCLK_LSB            12
`define DRV_ADDR_LSB            8
`define DRV_SEL_LSB             4
`define DRV_CKE_LSB             0

// Clock rate register layout.
`define RATE_VALID_BIT          3
`define RATE_RESET              32'h00000000
`define RATE_RW_MASK            32'h0000000F

// Delivery time of an indirect write to the interface logic, and its cycle count at 10 MHz.
`define DELIVER_NS              200
`define CLK_NS                  100
`define DELIVER_CYC             ((`DELIVER_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* hdl/dram_phy_cfg_pkg.sv */
// Types shared by the DRAM interface configuration block.
package dram_phy_cfg_pkg;

  // Decoded memory clock rate.
  typedef enum logic [1:0] {
    RATE_NONE,
    RATE_266,
    RATE_333,
    RATE_400
  } clock_rate_t;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sel;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cfg_req_t;

  // Drive and termination settings as applied to the interface logic.
  typedef struct packed {
    logic [1:0] on_die_termination_select;
    logic       termination_active;
    logic [1:0] strobe_drive_strength;
    logic [1:0] data_pin_drive_strength;
    logic [1:0] memory_clock_drive_strength;
    logic [1:0] address_command_drive_strength;
    logic [1:0] select_termination_drive_strength;
    logic [1:0] clock_enable_drive_strength;
  } drive_cfg_t;

endpackage

/* hdl/dram_phy_indirect_config.sv */
// Top of the two-channel DRAM interface configuration window.
`timescale 1ns/1ps
`default_nettype none
`include "dram_phy_cfg_defs.svh"
//
// Contract
// - Rate codes 1,2,3 give 266/333/400 MHz.
// - Ignore channel one rate if ganged or invalid.
// - Each channel has index, data port, private array.
// - Index bits 29:0 select array register, read-write.
// - Bit 30 selects read (0) or write (1).
// - Complete flag reads done; resets to set.
// - Write completes only after reaching interface logic.
// - Both channels keep independent values even ganged.
// - Register 00 resets 00111222h; termination field 29:28.
// - Strobe drive bits 21:20, reset 01b.
// - Data drive bits 17:16, reset 01b.
// - Memory clock drive bits 13:12.
// - Address/command drive bits 9:8, reset 10b.
// - Select/termination drive bits 5:4, reset 10b.
// - Clock enable drive bits 1:0, reset 10b.
module dram_phy_indirect_config
  import dram_phy_cfg_pkg::*;
#(
  parameter int DELIVER_CYCLES = `DELIVER_CYC
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Configuration register port, one select per channel.
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [1:0]  i_cfg_channel_sel,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  // Mode and interface acknowledges.
  input  wire logic        i_ganged,
  input  wire logic [1:0]  i_termination_disable,
  input  wire logic [1:0]  i_phy_ack,
  // Settings toward the interface logic.
  output drive_cfg_t       o_drive_ch0,
  output drive_cfg_t       o_drive_ch1,
  output logic [1:0]       o_phy_write,
  output clock_rate_t      o_rate_ch0,
  output clock_rate_t      o_rate_ch1
);

  cfg_req_t    req0;
  cfg_req_t    req1;
  logic [31:0] rdata0;
  logic [31:0] rdata1;
  logic [31:0] rate0_q;
  logic [31:0] rate1_q;
  logic [31:0] rdata_q;
  drive_cfg_t  drv0;
  drive_cfg_t  drv1;

  // Channel requests are steered by the channel select; each channel keeps its own state.
  always_comb begin
    req0 = '{wr: i_cfg_wr, rd: i_cfg_rd, sel: i_cfg_channel_sel[0],
             addr: i_cfg_addr, wdata: i_cfg_wdata};
    req1 = '{wr: i_cfg_wr, rd: i_cfg_rd, sel: i_cfg_channel_sel[1],
             addr: i_cfg_addr, wdata: i_cfg_wdata};
  end

  indirect_channel #(
    .DELIVER_CYCLES (DELIVER_CYCLES)
  ) u_ch0 (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_req       (req0),
    .o_rdata     (rdata0),
    .i_phy_ack   (i_phy_ack[0]),
    .o_drive     (drv0),
    .o_phy_write (o_phy_write[0])
  );

  indirect_channel #(
    .DELIVER_CYCLES (DELIVER_CYCLES)
  ) u_ch1 (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_req       (req1),
    .o_rdata     (rdata1),
    .i_phy_ack   (i_phy_ack[1]),
    .o_drive     (drv1),
    .o_phy_write (o_phy_write[1])
  );

  // Clock rate registers, one per channel: rate in 2:0, valid in 3.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rate0_q <= `RATE_RESET;
      rate1_q <= `RATE_RESET;
    end else if (i_cfg_wr && i_cfg_addr == `OFS_CLOCK_RATE) begin
      if (i_cfg_channel_sel[0]) begin
        rate0_q <= i_cfg_wdata & `RATE_RW_MASK;
      end
      if (i_cfg_channel_sel[1]) begin
        rate1_q <= i_cfg_wdata & `RATE_RW_MASK;
      end
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 32'h00000000;
    end else if (i_cfg_rd) begin
      if (i_cfg_addr == `OFS_CLOCK_RATE) begin
        rdata_q <= i_cfg_channel_sel[1] ? rate1_q : rate0_q;
      end else begin
        rdata_q <= i_cfg_channel_sel[1] ? rdata1 : rdata0;
      end
    end
  end

  assign o_cfg_rdata = rdata_q;

  rate_decode u_rate0 (
    .i_memory_clock_rate_select (rate0_q[2:0]),
    .i_enable                   (rate0_q[`RATE_VALID_BIT]),
    .o_rate                     (o_rate_ch0)
  );

  // Channel one's field is ignored when ganged or not valid.
  rate_decode u_rate1 (
    .i_memory_clock_rate_select (rate1_q[2:0]),
    .i_enable                   (rate1_q[`RATE_VALID_BIT] && !i_ganged),
    .o_rate                     (o_rate_ch1)
  );

  // Termination setting applies only while termination is enabled.
  always_comb begin
    o_drive_ch0 = drv0;
    o_drive_ch1 = drv1;
    o_drive_ch0.termination_active = !i_termination_disable[0];
    o_drive_ch1.termination_active = !i_termination_disable[1];
  end

endmodule
`default_nettype wire

/* hdl/indirect_channel.sv */
// Per-channel index/data port pair with its indirect driver register.
`timescale 1ns/1ps
`default_nettype none
`include "dram_phy_cfg_defs.svh"
module indirect_channel
  import dram_phy_cfg_pkg::*;
#(
  parameter int DELIVER_CYCLES = `DELIVER_CYC
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Register port for this channel.
  input  wire cfg_req_t    i_req,
  output logic [31:0]      o_rdata,
  // Delivery acknowledge from the interface logic.
  input  wire logic        i_phy_ack,
  // Settings applied to the interface logic.
  output drive_cfg_t       o_drive,
  output logic             o_phy_write
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } acc_state_t;

  acc_state_t  state_q;
  logic [31:0] index_q;
  logic [31:0] data_q;
  logic [31:0] drv_q;
  logic [31:0] drv_shadow_q;
  logic [7:0]  wait_q;
  logic        index_wr;
  logic        data_wr;

  assign index_wr = i_req.sel && i_req.wr && (i_req.addr == `OFS_INDIRECT_INDEX);
  assign data_wr  = i_req.sel && i_req.wr && (i_req.addr == `OFS_INDIRECT_DATA_PORT);

  // Index register: offset and write select are stored, the complete flag is hardware's.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      index_q <= `INDEX_RESET;
    end else if (index_wr) begin
      index_q <= i_req.wdata & `INDEX_RW_MASK;
    end else if (state_q != ST_IDLE && wait_q == 8'h00 && (state_q == ST_READ || i_phy_ack)) begin
      index_q[`INDEX_COMPLETE_BIT] <= 1'b1;
    end
  end

  // Access sequencer: reads take one cycle, writes wait for delivery and the acknowledge.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      wait_q  <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (index_wr) begin
            state_q <= i_req.wdata[`INDEX_WRITE_BIT] ? ST_WRITE : ST_READ;
            // Only writes wait for delivery; a read completes on its single cycle.
            wait_q  <= i_req.wdata[`INDEX_WRITE_BIT] ? 8'(DELIVER_CYCLES) : 8'h00;
          end
        end
        ST_READ: begin
          state_q <= ST_IDLE;
        end
        ST_WRITE: begin
          if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
          end else if (i_phy_ack) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Data port holds write data from software and read results from the array.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_q <= 32'h00000000;
    end else if (data_wr) begin
      data_q <= i_req.wdata;
    end else if (state_q == ST_READ) begin
      if (index_q[29:0] == `IDX_OUTPUT_DRIVER) begin
        data_q <= drv_q;
      end else begin
        data_q <= 32'h00000000;
      end
    end
  end

  // Shadow takes the write when the access starts; the applied copy changes on delivery.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drv_shadow_q <= `DRV_RESET;
      drv_q        <= `DRV_RESET;
    end else begin
      if (index_wr && i_req.wdata[`INDEX_WRITE_BIT]
          && i_req.wdata[29:0] == `IDX_OUTPUT_DRIVER) begin
        drv_shadow_q <= data_q & `DRV_RW_MASK;
      end
      if (state_q == ST_WRITE && wait_q == 8'h00 && i_phy_ack
          && index_q[29:0] == `IDX_OUTPUT_DRIVER) begin
        drv_q <= drv_shadow_q;
      end
    end
  end

  assign o_phy_write = (state_q == ST_WRITE);

  // Read mux for this channel's ports.
  always_comb begin
    o_rdata = 32'h00000000;
    if (i_req.addr == `OFS_INDIRECT_INDEX) begin
      o_rdata = index_q;
    end else if (i_req.addr == `OFS_INDIRECT_DATA_PORT) begin
      o_rdata = data_q;
    end
  end

  // Field split of the applied driver register.
  always_comb begin
    o_drive.on_die_termination_select         = drv_q[`DRV_ODT_LSB +: 2];
    o_drive.termination_active                = 1'b1;
    o_drive.strobe_drive_strength             = drv_q[`DRV_STROBE_LSB +: 2];
    o_drive.data_pin_drive_strength           = drv_q[`DRV_DATA_LSB +: 2];
    o_drive.memory_clock_drive_strength       = drv_q[`DRV_MCLK_LSB +: 2];
    o_drive.address_command_drive_strength    = drv_q[`DRV_ADDR_LSB +: 2];
    o_drive.select_termination_drive_strength = drv_q[`DRV_SEL_LSB +: 2];
    o_drive.clock_enable_drive_strength       = drv_q[`DRV_CKE_LSB +: 2];
  end

endmodule
`default_nettype wire

/* hdl/rate_decode.sv */
// Memory clock rate decoder for one channel.
`timescale 1ns/1ps
`default_nettype none
module rate_decode
  import dram_phy_cfg_pkg::*;
(
  // Raw field and validity.
  input  wire logic [2:0] i_memory_clock_rate_select,
  input  wire logic       i_enable,
  // Decoded rate.
  output clock_rate_t     o_rate
);

  // Reserved codes and a disabled channel give no rate.
  always_comb begin
    o_rate = RATE_NONE;
    if (i_enable) begin
      case (i_memory_clock_rate_select)
        3'h1:    o_rate = RATE_266;
        3'h2:    o_rate = RATE_333;
        3'h3:    o_rate = RATE_400;
        default: o_rate = RATE_NONE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* sim/dram_phy_indirect_config_bench.sv */
// Self-checking bench for the DRAM interface configuration window.
`timescale 1ns/1ps
`default_nettype none
`include "dram_phy_cfg_defs.svh"
module dram_phy_indirect_config_bench
  import dram_phy_cfg_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ganged = 1'b1;
  logic [1:0]  sel = 2'b00, tdis = 2'b10, ack = 2'b11, pw;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  drive_cfg_t  drv0, drv1;
  clock_rate_t r0, r1;
  int          errors = 0, n_checks = 0;

  // A 100 ns clock.
  always #50 clk = ~clk;

  // Design under test with a short delivery wait.
  dram_phy_indirect_config #(.DELIVER_CYCLES(1)) dram_phy_indirect_config_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_channel_sel(sel),
    .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_ganged(ganged),
    .i_termination_disable(tdis), .i_phy_ack(ack), .o_drive_ch0(drv0),
    .o_drive_ch1(drv1), .o_phy_write(pw), .o_rate_ch0(r0), .o_rate_ch1(r1));

  // Compares one value and counts it.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  // One register write, strobe held across one rising edge.
  task automatic reg_wr(input logic [1:0] c, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {wr, sel, addr, wdata} = {1'b1, c, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask

  // One register read, data taken once it has settled.
  task automatic reg_rd(input logic [1:0] c, input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    {rd, sel, addr} = {1'b1, c, a};
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Polls the complete flag under a bounded count.
  task automatic poll(input logic [1:0] c);
    logic [31:0] d;
    d = 32'h0;
    for (int k = 0; k < 20 && d[31] !== 1'b1; k++) begin
      reg_rd(c, `OFS_INDIRECT_INDEX, d);
    end
    chk("complete", d[31], 1'b1);
  endtask

  // Indirect read of one array register.
  task automatic ind_rd(input logic [1:0] c, input logic [29:0] i, output logic [31:0] d);
    reg_wr(c, `OFS_INDIRECT_INDEX, {2'b00, i});
    poll(c);
    reg_rd(c, `OFS_INDIRECT_DATA_PORT, d);
  endtask

  // Reset values of both index registers and of register 00.
  task automatic t_reset();
    logic [31:0] d;
    reg_rd(2'b01, `OFS_INDIRECT_INDEX, d);
    chk("index0", d, 32'h80000000);
    reg_rd(2'b10, `OFS_INDIRECT_INDEX, d);
    chk("index1", d, 32'h80000000);
    chk("drive1", drv1, {2'b00, 1'b0, 2'b01, 2'b01, 2'b01, 2'b10, 2'b10, 2'b10});
    ind_rd(2'b10, 30'h0, d);
    chk("reg00", d, 32'h00111222);
    $display("reset test done");
  endtask

  // Ganged write held back by the interface, then delivered.
  task automatic t_write();
    logic [31:0] d;
    reg_wr(2'b01, `OFS_INDIRECT_DATA_PORT, 32'hDEADBEEF);
    ack[0] = 1'b0;
    reg_wr(2'b01, `OFS_INDIRECT_INDEX, 32'h40000000);
    repeat (2) reg_rd(2'b01, `OFS_INDIRECT_INDEX, d);
    chk("busy", {d[31], pw[0]}, 2'b01);
    ack[0] = 1'b1;
    poll(2'b01);
    chk("drive0", drv0, {2'b01, 1'b1, 2'b10, 2'b01, 2'b11, 2'b10, 2'b10, 2'b11});
    ind_rd(2'b01, 30'h0, d);
    chk("reg00 ch0", d, 32'h10213223);
    ind_rd(2'b10, 30'h0, d);
    chk("reg00 ch1", d, 32'h00111222);
    $display("write test done");
  endtask

  // Full index field, far array slot and an unmapped offset.
  task automatic t_index();
    logic [31:0] d;
    ind_rd(2'b10, 30'h3FFFFFFF, d);
    chk("far slot", d, 32'h0);
    reg_rd(2'b10, `OFS_INDIRECT_INDEX, d);
    chk("index rw", d, 32'hBFFFFFFF);
    reg_rd(2'b01, `OFS_INDIRECT_INDEX, d);
    chk("index ch0", d, 32'h80000000);
    reg_wr(2'b10, 8'h40, 32'hFFFFFFFF);
    reg_rd(2'b10, 8'h40, d);
    chk("unmapped", d, 32'h0);
    $display("index test done");
  endtask

  // Every rate code, then the channel one cases.
  task automatic t_rate();
    clock_rate_t t [8] = '{RATE_NONE, RATE_266, RATE_333, RATE_400,
                           RATE_NONE, RATE_NONE, RATE_NONE, RATE_NONE};
    for (int c = 0; c < 8; c++) begin
      reg_wr(2'b11, `OFS_CLOCK_RATE, 32'h8 | c);
      chk("rate0", r0, t[c]);
      chk("rate1 ganged", r1, RATE_NONE);
    end
    ganged = 1'b0;
    reg_wr(2'b11, `OFS_CLOCK_RATE, 32'hA);
    chk("rate1", r1, RATE_333);
    reg_wr(2'b10, `OFS_CLOCK_RATE, 32'h2);
    chk("rate1 invalid", r1, RATE_NONE);
    $display("rate test done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset for two cycles, then the scenarios.
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_write();
    t_index();
    t_rate();
    wrap_up();
  end

  // Cuts a hang short at 5000 cycles, far beyond the fewer than 100 cycles needed.
  initial begin
    #(5000 * 100);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire

/* sim/dram_phy_indirect_config_props.sv */
// Port-level checks for the DRAM interface configuration window.
`timescale 1ns/1ps
`default_nettype none
`include "dram_phy_cfg_defs.svh"
module dram_phy_indirect_config_props
  import dram_phy_cfg_pkg::*;
#(
  parameter int DELIVER_CYCLES = `DELIVER_CYC
) (
  // Clock and reset.
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // Register port.
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [1:0]  i_cfg_channel_sel,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  // Modes and interface side.
  input wire logic        i_ganged,
  input wire logic [1:0]  i_termination_disable,
  input wire logic [1:0]  i_phy_ack,
  input wire drive_cfg_t  o_drive_ch0,
  input wire logic [1:0]  o_phy_write,
  input wire clock_rate_t o_rate_ch1
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // An indirect write launched on an idle channel zero.
  sequence s_wr_start;
    i_cfg_wr && i_cfg_channel_sel[0] && i_cfg_addr == `OFS_INDIRECT_INDEX
      && i_cfg_wdata[`INDEX_WRITE_BIT] && !o_phy_write[0];
  endsequence
  // Channel zero outstanding while the interface accepts.
  sequence s_acked;
    o_phy_write[0] && i_phy_ack[0];
  endsequence

  // Write launch, delivery bounds and the settings it may change.
  chk_write_launch: assert property (s_wr_start |=> o_phy_write[0])
    else $error("indirect write did not start");
  chk_write_bounded: assert property (not (s_acked [*6]))
    else $error("acknowledged write never completed");
  chk_hold_no_ack: assert property (o_phy_write[0] && !i_phy_ack[0] |=> o_phy_write[0])
    else $error("write completed without delivery");
  chk_drive_gated: assert property ($changed({o_drive_ch0[14:13], o_drive_ch0[11:0]})
    |-> $past(o_phy_write[0]))
    else $error("drive settings changed outside a delivered write");
  chk_busy_flag: assert property (i_cfg_rd && i_cfg_channel_sel == 2'b01
    && i_cfg_addr == `OFS_INDIRECT_INDEX && o_phy_write[0] |=> !o_cfg_rdata[31])
    else $error("complete flag set while write outstanding");
  // Termination, ganged rate and read port behaviour.
  chk_term_follow: assert property (o_drive_ch0.termination_active == !i_termination_disable[0])
    else $error("termination enable does not follow disable input");
  chk_ganged_rate: assert property (i_ganged |-> o_rate_ch1 == RATE_NONE)
    else $error("channel one rate used while ganged");
  chk_rdata_hold: assert property (!i_cfg_rd |=> $stable(o_cfg_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (i_cfg_rd && i_cfg_addr[7:4] != 4'h9
    |=> o_cfg_rdata == 32'h0)
    else $error("unmapped offset read nonzero");
endmodule

bind dram_phy_indirect_config dram_phy_indirect_config_props #(
  .DELIVER_CYCLES(DELIVER_CYCLES)
) props_i (
  .i_clk, .i_rst_b, .i_cfg_wr, .i_cfg_rd, .i_cfg_channel_sel, .i_cfg_addr, .i_cfg_wdata,
  .o_cfg_rdata, .i_ganged, .i_termination_disable, .i_phy_ack, .o_drive_ch0,
  .o_phy_write, .o_rate_ch1
);
`default_nettype wire
